/* hdl/ppc_defines.svh */
// Register offsets, reset values and field positions of the port pin block.
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_OFS_P2_OUT_MODE   8'hA6
`define PPC_OFS_P3_OUT_MODE   8'hA7
`define PPC_OFS_P3_IN_MODE    8'hAF
`define PPC_OFS_P3_LATCH      8'hB0
`define PPC_OFS_P4_LATCH      8'hC8
`define PPC_OFS_P2_IN_MODE    8'hAE
`define PPC_OFS_CROSSBAR_CONFIG_TWO          8'hE3
`define PPC_RST_OUT_MODE      8'h00
`define PPC_RST_IN_MODE       8'hFF
`define PPC_RST_LATCH         8'hFF
`define PPC_RST_CROSSBAR_CONFIG_TWO          8'h00
`define PPC_CROSSBAR_CONFIG_TWO_PUD_BIT      7
`define PPC_CROSSBAR_CONFIG_TWO_LOWEN_BIT    1
`define PPC_CROSSBAR_CONFIG_TWO_MASK         8'h82
`define PPC_P4_WR_BIT         7
`define PPC_P4_RD_BIT         6
`define PPC_P4_ALE_BIT        5
`define PPC_BIT_SEL_W         3
`endif

/* hdl/ppc_pkg.sv */
// Types shared by the port pin block.
package ppc_pkg;
    typedef logic [7:0] ppc_byte_t;
    typedef enum logic [2:0] {
        PPC_IDLE  = 3'b001,
        PPC_XWR   = 3'b010,
        PPC_XRD   = 3'b100
    } ppc_xmode_e;
endpackage

/* hdl/ppc_sync.sv */
// Two-flop synchroniser for WIDTH bits of pin levels (8 by default).
`timescale 1ns/1ps
module ppc_sync
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and control
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

/* hdl/ppc_pin_drv.sv */
// Per-pin output driver and pullup control for one byte-wide port.
`timescale 1ns/1ps
module ppc_pin_drv
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Configuration
    input  wire logic [WIDTH-1:0] i_value,
    input  wire logic [WIDTH-1:0] i_push_pull,
    input  wire logic [WIDTH-1:0] i_force_od,
    input  wire logic [WIDTH-1:0] i_digital,
    input  wire logic             i_pud,
    input  wire logic [WIDTH-1:0] i_drv_off,
    // Pin controls
    output logic      [WIDTH-1:0] o_pin_o,
    output logic      [WIDTH-1:0] o_pin_oe,
    output logic      [WIDTH-1:0] o_pullup_en
);
    logic [WIDTH-1:0] pp_eff;
    logic [WIDTH-1:0] drive_low;

    assign pp_eff      = i_push_pull & ~i_force_od;
    assign drive_low   = ~i_value & ~i_drv_off;
    assign o_pin_o     = i_value;
    assign o_pin_oe    = (drive_low | (i_value & pp_eff)) & ~i_drv_off;
    assign o_pullup_en = i_digital & {WIDTH{~i_pud}} & ~drive_low;
endmodule

/* hdl/ppc_top.sv */
// Port 2/3 pin configuration, port 3/4 data latches and external memory takeover.
`timescale 1ns/1ps
`include "ppc_defines.svh"
module ppc_top
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    // Register port
    input  wire logic [7:0]       i_addr,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic             i_bit_op,
    input  wire logic [2:0]       i_bit_sel,
    input  wire logic             i_rmw,
    input  wire logic [WIDTH-1:0] i_wdata,
    output logic      [WIDTH-1:0] o_rdata,
    output logic                  o_rvalid,
    // Open-drain forcing from peripherals
    input  wire logic [WIDTH-1:0] i_p2_force_od,
    input  wire logic [WIDTH-1:0] i_p3_force_od,
    input  wire logic [WIDTH-1:0] i_p4_force_od,
    // External memory interface
    input  wire logic             i_xm_high_en,
    input  wire logic             i_xm_active,
    input  wire logic             i_xm_read,
    input  wire logic [WIDTH-1:0] i_xm_ad,
    input  wire logic             i_xm_wr_n,
    input  wire logic             i_xm_rd_n,
    input  wire logic             i_xm_ale,
    // Port 2 pins
    input  wire logic [WIDTH-1:0] i_p2_pin,
    output logic      [WIDTH-1:0] o_p2_pin,
    output logic      [WIDTH-1:0] o_p2_oe,
    output logic      [WIDTH-1:0] o_p2_pullup,
    // Port 3 pins
    input  wire logic [WIDTH-1:0] i_p3_pin,
    output logic      [WIDTH-1:0] o_p3_pin,
    output logic      [WIDTH-1:0] o_p3_oe,
    output logic      [WIDTH-1:0] o_p3_pullup,
    // Port 4 pins
    input  wire logic [WIDTH-1:0] i_p4_pin,
    output logic      [WIDTH-1:0] o_p4_pin,
    output logic      [WIDTH-1:0] o_p4_oe,
    output logic      [WIDTH-1:0] o_p4_pullup,
    // Status
    output logic                  o_xm_mode_warn
);
    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Applies a byte write or a single-bit write to a register value.
    function automatic logic [WIDTH-1:0] apply_wr(input logic [WIDTH-1:0] cur,
                                                  input logic [WIDTH-1:0] wd,
                                                  input logic             bit_op,
                                                  input logic [2:0]       sel);
        logic [WIDTH-1:0] res;
        res = cur;
        if (bit_op) begin
            res[sel] = wd[0];
        end else begin
            res = wd;
        end
        return res;
    endfunction

    // Returns the addressed bit in bit 0 for bit reads, or the byte.
    function automatic logic [WIDTH-1:0] pick_rd(input logic [WIDTH-1:0] val,
                                                 input logic             bit_op,
                                                 input logic [2:0]       sel);
        logic [WIDTH-1:0] res;
        res = '0;
        if (bit_op) begin
            res[0] = val[sel];
        end else begin
            res = val;
        end
        return res;
    endfunction

    // Masks synchronised pin levels with the input-mode bits; analog pins read 0.
    function automatic logic [WIDTH-1:0] digital_in(input logic [WIDTH-1:0] lvl,
                                                    input logic [WIDTH-1:0] mode);
        return lvl & mode;
    endfunction

    // Chooses the latch for read-modify-write reads and the pin level otherwise.
    function automatic logic [WIDTH-1:0] rmw_src(input logic             rmw,
                                                 input logic [WIDTH-1:0] latch,
                                                 input logic [WIDTH-1:0] lvl);
        return rmw ? latch : lvl;
    endfunction

    // True when the register address matches the given offset.
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] p2_out_mode_q;
    logic [WIDTH-1:0] p3_out_mode_q;
    logic [WIDTH-1:0] p2_in_mode_q;
    logic [WIDTH-1:0] p3_in_mode_q;
    logic [WIDTH-1:0] p3_latch_q;
    logic [WIDTH-1:0] p4_latch_q;
    logic [7:0]       crossbar_config_two_q;
    logic [WIDTH-1:0] rdata_q;
    logic             rvalid_q;
    ppc_xmode_e       xmode_q;
    ppc_xmode_e       xmode_d;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire sel_p2_om = addr_hit(i_addr, `PPC_OFS_P2_OUT_MODE);
    wire sel_p3_om = addr_hit(i_addr, `PPC_OFS_P3_OUT_MODE);
    wire sel_p2_im = addr_hit(i_addr, `PPC_OFS_P2_IN_MODE);
    wire sel_p3_im = addr_hit(i_addr, `PPC_OFS_P3_IN_MODE);
    wire sel_p3_l  = addr_hit(i_addr, `PPC_OFS_P3_LATCH);
    wire sel_p4_l  = addr_hit(i_addr, `PPC_OFS_P4_LATCH);
    wire sel_crossbar_config_two  = addr_hit(i_addr, `PPC_OFS_CROSSBAR_CONFIG_TWO);
    wire sel_latch = sel_p3_l | sel_p4_l;
    wire wr_en     = i_ce & i_wr;
    // Bit accesses apply only to the latch registers; elsewhere the byte is written.
    wire bit_wr    = i_bit_op & sel_latch;

    wire pud       = crossbar_config_two_q[`PPC_CROSSBAR_CONFIG_TWO_PUD_BIT];
    wire low_en    = crossbar_config_two_q[`PPC_CROSSBAR_CONFIG_TWO_LOWEN_BIT];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] p2_sync;
    logic [WIDTH-1:0] p3_sync;
    logic [WIDTH-1:0] p4_sync;

    ppc_sync #(.WIDTH(3 * WIDTH)) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async ({i_p4_pin, i_p3_pin, i_p2_pin}),
        .o_sync  ({p4_sync, p3_sync, p2_sync})
    );

    // Digital path gated by input mode; port 4 has no input-mode register here.
    wire [WIDTH-1:0] p2_level = digital_in(p2_sync, p2_in_mode_q);
    wire [WIDTH-1:0] p3_level = digital_in(p3_sync, p3_in_mode_q);
    wire [WIDTH-1:0] p4_level = p4_sync;

    // Read-modify-write reads see the latch instead of the pin.
    wire [WIDTH-1:0] p3_rd = rmw_src(i_rmw, p3_latch_q, p3_level);
    wire [WIDTH-1:0] p4_rd = rmw_src(i_rmw, p4_latch_q, p4_level);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [WIDTH-1:0] rd_mux =
        sel_p2_om ? p2_out_mode_q :
        sel_p3_om ? p3_out_mode_q :
        sel_p2_im ? p2_in_mode_q  :
        sel_p3_im ? p3_in_mode_q  :
        sel_p3_l  ? pick_rd(p3_rd, i_bit_op, i_bit_sel) :
        sel_p4_l  ? pick_rd(p4_rd, i_bit_op, i_bit_sel) :
        sel_crossbar_config_two  ? (crossbar_config_two_q & `PPC_CROSSBAR_CONFIG_TWO_MASK) :
        '0;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            p2_out_mode_q <= `PPC_RST_OUT_MODE;
            p3_out_mode_q <= `PPC_RST_OUT_MODE;
            p2_in_mode_q  <= `PPC_RST_IN_MODE;
            p3_in_mode_q  <= `PPC_RST_IN_MODE;
            crossbar_config_two_q        <= `PPC_RST_CROSSBAR_CONFIG_TWO;
        end else if (wr_en) begin
            if (sel_p2_om) begin
                p2_out_mode_q <= i_wdata;
            end
            if (sel_p3_om) begin
                p3_out_mode_q <= i_wdata;
            end
            if (sel_p2_im) begin
                p2_in_mode_q <= i_wdata;
            end
            if (sel_p3_im) begin
                p3_in_mode_q <= i_wdata;
            end
            if (sel_crossbar_config_two) begin
                crossbar_config_two_q <= i_wdata & `PPC_CROSSBAR_CONFIG_TWO_MASK;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            p3_latch_q <= `PPC_RST_LATCH;
            p4_latch_q <= `PPC_RST_LATCH;
        end else if (wr_en) begin
            if (sel_p3_l) begin
                p3_latch_q <= apply_wr(p3_latch_q, i_wdata, bit_wr, i_bit_sel);
            end
            if (sel_p4_l) begin
                p4_latch_q <= apply_wr(p4_latch_q, i_wdata, bit_wr, i_bit_sel);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else if (i_ce) begin
            rvalid_q <= i_rd;
            if (i_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // External move tracking
    // ----------------------------------------------------------------
    wire xm_take = i_xm_high_en & i_xm_active;

    always_comb begin
        xmode_d = PPC_IDLE;
        case (xmode_q)
            PPC_IDLE, PPC_XWR, PPC_XRD: begin
                if (xm_take) begin
                    xmode_d = i_xm_read ? PPC_XRD : PPC_XWR;
                end else begin
                    xmode_d = PPC_IDLE;
                end
            end
            default: xmode_d = PPC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            xmode_q <= PPC_IDLE;
        end else if (i_ce) begin
            xmode_q <= xmode_d;
        end
    end

    // Combinational takeover so the strobes follow the interface without lag.
    wire xm_rd_now = xm_take & i_xm_read;

    logic [WIDTH-1:0] p4_xm_val;
    logic [WIDTH-1:0] p4_xm_mask;
    always_comb begin
        p4_xm_val  = p4_latch_q;
        p4_xm_mask = '0;
        if (xm_take) begin
            p4_xm_val[`PPC_P4_WR_BIT]  = i_xm_wr_n;
            p4_xm_val[`PPC_P4_RD_BIT]  = i_xm_rd_n;
            p4_xm_val[`PPC_P4_ALE_BIT] = i_xm_ale;
        end
    end

    wire [WIDTH-1:0] p3_val   = xm_take ? i_xm_ad : p3_latch_q;
    wire [WIDTH-1:0] p3_off   = {WIDTH{xm_rd_now}};
    wire [WIDTH-1:0] p4_pp    = '0;

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Port 2 has no data latch here, so its pins drive high only in push-pull mode.
    ppc_pin_drv #(.WIDTH(WIDTH)) u_drv_p2 (
        .i_value     ({WIDTH{1'b1}}),
        .i_push_pull (p2_out_mode_q),
        .i_force_od  (i_p2_force_od),
        .i_digital   (p2_in_mode_q),
        .i_pud       (pud),
        .i_drv_off   (p4_xm_mask),
        .o_pin_o     (o_p2_pin),
        .o_pin_oe    (o_p2_oe),
        .o_pullup_en (o_p2_pullup)
    );

    ppc_pin_drv #(.WIDTH(WIDTH)) u_drv_p3 (
        .i_value     (p3_val),
        .i_push_pull (p3_out_mode_q),
        .i_force_od  (i_p3_force_od),
        .i_digital   (p3_in_mode_q),
        .i_pud       (pud),
        .i_drv_off   (p3_off),
        .o_pin_o     (o_p3_pin),
        .o_pin_oe    (o_p3_oe),
        .o_pullup_en (o_p3_pullup)
    );

    ppc_pin_drv #(.WIDTH(WIDTH)) u_drv_p4 (
        .i_value     (p4_xm_val),
        .i_push_pull (p4_pp),
        .i_force_od  (i_p4_force_od),
        .i_digital   ({WIDTH{1'b1}}),
        .i_pud       (pud),
        .i_drv_off   (p4_xm_mask),
        .o_pin_o     (o_p4_pin),
        .o_pin_oe    (o_p4_oe),
        .o_pullup_en (o_p4_pullup)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata        = rdata_q;
    assign o_rvalid       = rvalid_q;
    // Flags the configuration software should avoid.
    assign o_xm_mode_warn = i_xm_high_en & low_en;
endmodule

/* bench/ppc_top_monitor.sv */
// Concurrent checks on the ports of the port pin block.
`timescale 1ns/1ps
`include "ppc_defines.svh"
module ppc_top_monitor (
    // Clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_ce,
    input wire logic [7:0] i_addr,
    input wire logic       i_rd,
    input wire logic       i_rmw,
    input wire logic       i_bit_op,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rvalid,
    // External memory interface and forcing
    input wire logic       i_xm_high_en,
    input wire logic       i_xm_active,
    input wire logic       i_xm_read,
    input wire logic [7:0] i_xm_ad,
    input wire logic       i_xm_wr_n,
    input wire logic       i_xm_rd_n,
    input wire logic       i_xm_ale,
    input wire logic [7:0] i_p3_force_od,
    // Pin controls
    input wire logic [7:0] o_p3_pin,
    input wire logic [7:0] o_p3_oe,
    input wire logic [7:0] o_p3_pullup,
    input wire logic [7:0] o_p4_pin,
    input wire logic [7:0] o_p4_oe,
    input wire logic [7:0] o_p4_pullup
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire xm_on = i_xm_high_en && i_xm_active;

    a_reset_drive_off: assert property (
        $fell(i_reset) && !xm_on |-> o_p3_oe == 8'h00 && o_p4_oe == 8'h00)
        else $error("pins driven right after reset");
    a_reset_pullups_on: assert property (
        $fell(i_reset) |-> o_p3_pullup == 8'hFF && o_p4_pullup == 8'hFF)
        else $error("pullups off right after reset");
    a_read_answer_timing: assert property (
        i_ce |=> o_rvalid == $past(i_rd))
        else $error("read valid not one cycle after read");
    a_rmw_reads_latch: assert property (
        i_ce && i_rd && i_rmw && !i_bit_op && i_addr == `PPC_OFS_P3_LATCH && !xm_on
        |=> o_rdata == $past(o_p3_pin))
        else $error("read-modify-write read did not return latch");
    a_low_no_pullup: assert property (
        (o_p3_pullup & o_p3_oe & ~o_p3_pin) == 8'h00
        && (o_p4_pullup & o_p4_oe & ~o_p4_pin) == 8'h00)
        else $error("pullup on while pin driven low");
    a_forced_open_drain: assert property (
        !xm_on |-> (i_p3_force_od & o_p3_oe & o_p3_pin) == 8'h00)
        else $error("forced pin driven high");
    a_latch_low_drives: assert property (
        !xm_on |-> (~o_p3_pin & ~o_p3_oe) == 8'h00 && (~o_p4_pin & ~o_p4_oe) == 8'h00)
        else $error("low latch bit not driven");
    a_xm_owns_bus: assert property (
        xm_on && !i_xm_read |-> o_p3_pin == i_xm_ad)
        else $error("bus value not from memory interface");
    a_xm_strobes: assert property (
        xm_on |-> o_p4_pin[7:5] == {i_xm_wr_n, i_xm_rd_n, i_xm_ale})
        else $error("strobes not on port 4");
    a_xm_read_float: assert property (
        xm_on && i_xm_read |-> o_p3_oe == 8'h00)
        else $error("bus driven during external read");
    c_xm_read: cover property (xm_on && i_xm_read);
    c_rmw_read: cover property (i_rd && i_rmw);
    c_reset_release: cover property ($fell(i_reset));
endmodule

/* bench/ppc_pin_model.sv */
// External circuit on one port: resolves each pin from drivers and pullups.
`timescale 1ns/1ps
module ppc_pin_model (
    // Device side
    input  wire logic       i_clk,
    input  wire logic [7:0] i_pin,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    // External driver
    input  wire logic [7:0] i_ext,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_level
);
    logic [7:0] last_q;
    always_ff @(posedge i_clk) begin
        last_q <= o_level;
    end
    // A pin that nobody drives and no pullup holds shows the inverse of its last level.
    assign o_level = (i_oe & i_pin) | (~i_oe & i_ext_en & i_ext)
                   | (~i_oe & ~i_ext_en & (i_pullup | ~last_q));
endmodule

/* bench/testbench.sv */
// Self-checking bench for the port pin block.
`timescale 1ns/1ps
`include "ppc_defines.svh"
module testbench;
    logic       i_clk = 0, i_reset = 1, i_ce = 1, i_wr = 0, i_rd = 0, i_bit_op = 0, i_rmw = 0;
    logic       i_xm_high_en = 0, i_xm_active = 0, i_xm_read = 0;
    logic       i_xm_wr_n = 1, i_xm_rd_n = 1, i_xm_ale = 0, o_rvalid, o_xm_mode_warn;
    logic [2:0] i_bit_sel = 3'h0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_p3_force_od = 8'h00, i_xm_ad = 8'h00;
    logic [7:0] ext3 = 8'h00, ext3_en = 8'h00, rd_q, p2_lvl, p3_lvl, p4_lvl, o_rdata;
    logic [7:0] i_p2_force_od = 8'h00;
    logic [7:0] o_p2_pin, o_p2_oe, o_p2_pullup, o_p3_pin, o_p3_oe, o_p3_pullup;
    logic [7:0] o_p4_pin, o_p4_oe, o_p4_pullup;
    int         n_mismatch = 0, num_checks = 0;

    always #20 i_clk = ~i_clk;

    ppc_top i_dut (.i_clk, .i_reset, .i_ce, .i_addr, .i_wr, .i_rd, .i_bit_op, .i_bit_sel,
        .i_rmw, .i_wdata, .o_rdata, .o_rvalid, .i_p2_force_od, .i_p3_force_od,
        .i_p4_force_od(8'h00), .i_xm_high_en, .i_xm_active, .i_xm_read, .i_xm_ad,
        .i_xm_wr_n, .i_xm_rd_n, .i_xm_ale, .i_p2_pin(p2_lvl), .o_p2_pin, .o_p2_oe,
        .o_p2_pullup, .i_p3_pin(p3_lvl), .o_p3_pin, .o_p3_oe, .o_p3_pullup,
        .i_p4_pin(p4_lvl), .o_p4_pin, .o_p4_oe, .o_p4_pullup, .o_xm_mode_warn);
    ppc_pin_model i_m2 (.i_clk, .i_pin(o_p2_pin), .i_oe(o_p2_oe), .i_pullup(o_p2_pullup),
        .i_ext(8'h00), .i_ext_en(8'h00), .o_level(p2_lvl));
    ppc_pin_model i_m3 (.i_clk, .i_pin(o_p3_pin), .i_oe(o_p3_oe), .i_pullup(o_p3_pullup),
        .i_ext(ext3), .i_ext_en(ext3_en), .o_level(p3_lvl));
    ppc_pin_model i_m4 (.i_clk, .i_pin(o_p4_pin), .i_oe(o_p4_oe), .i_pullup(o_p4_pullup),
        .i_ext(8'h00), .i_ext_en(8'h00), .o_level(p4_lvl));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b,
                      input logic [2:0] s);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_bit_op <= b;
        i_bit_sel <= s;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_bit_op <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic m, input logic b, input logic [2:0] s);
        @(posedge i_clk);
        i_addr <= a;
        i_rmw <= m;
        i_bit_op <= b;
        i_bit_sel <= s;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        i_rmw <= 1'b0;
        i_bit_op <= 1'b0;
        #1;
        chk("read valid", 8'h01, {7'h00, o_rvalid});
        rd_q = o_rdata;
    endtask

    task automatic t_reset();
        logic [7:0] ofs [8] = '{8'hA6, 8'hA7, 8'hAF, 8'hAE, 8'hE3, 8'hB0, 8'hC8, 8'h55};
        logic [7:0] exp [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00};
        @(posedge i_clk);
        #1;
        chk("p3 enables", 8'h00, o_p3_oe);
        chk("p3 pullups", 8'hFF, o_p3_pullup);
        for (int k = 0; k < 8; k++) begin
            rd(ofs[k], 1'b1, 1'b0, 3'h0);
            chk("reset value", exp[k], rd_q);
        end
        $display("done reset values");
    endtask

    task automatic t_drive();
        wr(`PPC_OFS_P3_LATCH, 8'h5A, 1'b0, 3'h0);
        wr(`PPC_OFS_P3_OUT_MODE, 8'h0F, 1'b0, 3'h0);
        chk("p3 enables", 8'hAF, o_p3_oe);
        chk("p3 driven level", 8'h0A, o_p3_pin & o_p3_oe);
        chk("p3 pullups", 8'h5A, o_p3_pullup);
        @(posedge i_clk);
        i_p3_force_od <= 8'h0A;
        @(posedge i_clk);
        #1;
        chk("forced enables", 8'hA5, o_p3_oe);
        @(posedge i_clk);
        i_p3_force_od <= 8'h00;
        wr(`PPC_OFS_P2_OUT_MODE, 8'hFF, 1'b0, 3'h0);
        chk("p2 enables", 8'hFF, o_p2_oe);
        @(posedge i_clk);
        i_p2_force_od <= 8'h0F;
        @(posedge i_clk);
        #1;
        chk("p2 forced enables", 8'hF0, o_p2_oe);
        i_p2_force_od <= 8'h00;
        wr(`PPC_OFS_P2_IN_MODE, 8'h0F, 1'b0, 3'h0);
        chk("p2 analog pullups", 8'h0F, o_p2_pullup);
        wr(`PPC_OFS_P2_IN_MODE, 8'hFF, 1'b0, 3'h0);
        wr(`PPC_OFS_P2_OUT_MODE, 8'h00, 1'b0, 3'h0);
        wr(`PPC_OFS_P3_OUT_MODE, 8'h00, 1'b0, 3'h0);
        wr(`PPC_OFS_P3_LATCH, 8'hFF, 1'b0, 3'h0);
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(`PPC_OFS_P3_OUT_MODE, 8'hFF, 1'b0, 3'h0);
        chk("frozen enables", 8'h00, o_p3_oe);
        i_ce <= 1'b1;
        $display("done output drive");
    endtask

    task automatic t_read();
        ext3 <= 8'h3C;
        ext3_en <= 8'hFF;
        wr(`PPC_OFS_P3_IN_MODE, 8'hF0, 1'b0, 3'h0);
        chk("p3 analog pullups", 8'hF0, o_p3_pullup);
        repeat (3) @(posedge i_clk);
        rd(`PPC_OFS_P3_LATCH, 1'b0, 1'b0, 3'h0);
        chk("p3 pin read", 8'h30, rd_q);
        rd(`PPC_OFS_P3_LATCH, 1'b1, 1'b0, 3'h0);
        chk("p3 latch read", 8'hFF, rd_q);
        rd(`PPC_OFS_P3_LATCH, 1'b0, 1'b1, 3'h5);
        chk("p3 bit read", 8'h01, rd_q);
        wr(`PPC_OFS_CROSSBAR_CONFIG_TWO, 8'hFF, 1'b0, 3'h0);
        chk("pullups disabled", 8'h00, o_p3_pullup);
        rd(`PPC_OFS_CROSSBAR_CONFIG_TWO, 1'b0, 1'b0, 3'h0);
        chk("crossbar read", 8'h82, rd_q);
        wr(`PPC_OFS_CROSSBAR_CONFIG_TWO, 8'h00, 1'b0, 3'h0);
        wr(`PPC_OFS_P4_LATCH, 8'h00, 1'b1, 3'h3);
        chk("p4 pullups", 8'hF7, o_p4_pullup);
        rd(`PPC_OFS_P4_LATCH, 1'b1, 1'b0, 3'h0);
        chk("p4 latch read", 8'hF7, rd_q);
        rd(`PPC_OFS_P4_LATCH, 1'b0, 1'b0, 3'h0);
        chk("p4 pin read", 8'hF7, rd_q);
        wr(`PPC_OFS_P4_LATCH, 8'hFF, 1'b0, 3'h0);
        wr(`PPC_OFS_P3_IN_MODE, 8'hFF, 1'b0, 3'h0);
        ext3_en <= 8'h00;
        $display("done port reads");
    endtask

    task automatic t_xm();
        @(posedge i_clk);
        i_xm_high_en <= 1'b1;
        i_xm_active <= 1'b1;
        i_xm_ad <= 8'h96;
        i_xm_wr_n <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("bus value", 8'h96, o_p3_pin);
        chk("p4 strobes", 8'h02, {5'h00, o_p4_pin[7:5]});
        i_xm_read <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("bus enables on read", 8'h00, o_p3_oe);
        i_xm_active <= 1'b0;
        i_xm_read <= 1'b0;
        wr(`PPC_OFS_CROSSBAR_CONFIG_TWO, 8'h02, 1'b0, 3'h0);
        chk("mapping warning", 8'h01, {7'h00, o_xm_mode_warn});
        chk("p3 enables after move", 8'h00, o_p3_oe);
        wr(`PPC_OFS_CROSSBAR_CONFIG_TWO, 8'h00, 1'b0, 3'h0);
        i_xm_high_en <= 1'b0;
        $display("done memory takeover");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_drive();
        t_read();
        t_xm();
        complete_run();
    end
endmodule

bind ppc_top ppc_top_monitor i_mon (.i_clk, .i_reset, .i_ce, .i_addr, .i_rd, .i_rmw,
    .i_bit_op, .o_rdata, .o_rvalid, .i_xm_high_en, .i_xm_active, .i_xm_read, .i_xm_ad,
    .i_xm_wr_n, .i_xm_rd_n, .i_xm_ale, .i_p3_force_od, .o_p3_pin, .o_p3_oe, .o_p3_pullup,
    .o_p4_pin, .o_p4_oe, .o_p4_pullup);
